// *** hdl/e3_tx_payload_input_interface.sv ***
// Function
// - national bit carries path maintenance link, or user link when selected
// - serial payload sampled on rising edge of loop or local reference clock
// - serial input used only while the nibble strap is low
// - nibble bus sampled on each rising edge of the outgoing nibble clock
// - nibble bus used only while the nibble strap is high
// - nibble clock derived from the selected transmit timing reference
// - overhead warning pulses one bit period before each overhead bit
// - serial input ignored during overhead bit periods
// - end-of-frame pulse one bit period during last frame bit as master
// - frame slave starts new frame on each frame reference rising edge
// - nibble boundary output pulses during the last nibble of each frame
// - serial or nibble transfer, loop or local timing, chosen independently
// - master or slave choice exists only under local timing
// - exactly six interface modes
// - frame is 1536 bits, 12 overhead, the rest payload
// - loop timing ignores local reference and outputs recovered clock
`timescale 1ns/100ps
`default_nettype none

module e3_tx_payload_input_interface (
  input wire logic clock,
  input wire logic rst,
  input wire e3_tx_pkg::reg_req_t regReq,
  output logic [7:0] rdData,
  input wire logic nibble_interface_strap,
  input wire logic tx_local_ref_clock_in,
  input wire logic recovered_line_clock_in,
  input wire logic tx_serial_payload_in,
  input wire logic [3:0] tx_nibble_payload_in,
  input wire logic tx_frame_reference_in,
  output logic loop_payload_clock_out,
  output logic tx_nibble_clock_out,
  output logic tx_overhead_warning_out,
  output logic tx_end_of_frame_out,
  output logic tx_nibble_frame_boundary_out,
  output e3_tx_pkg::payload_out_t payloadOut,
  output e3_tx_pkg::iface_mode_t mode
);

  import e3_tx_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------

  // overhead bits sit at the head of the frame
  function automatic logic isOverhead(input logic [COUNT_W-1:0] idx);
    isOverhead = (idx < FIRST_PAYLOAD_BIT);
  endfunction

  function automatic logic [COUNT_W-1:0] followingBit(input logic [COUNT_W-1:0] idx);
    if (idx == LAST_BIT) begin
      followingBit = '0;
    end else begin
      followingBit = idx + 11'h001;
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] pinsSynced;
  logic strapSync;
  logic refClockSync;
  logic lineClockSync;
  logic serialSync;
  logic frameRefSync;
  logic [3:0] nibbleSync;

  sync_two_flop #(
    .WIDTH(5)
  ) pinSync (
    .clock(clock),
    .rst(rst),
    .asyncIn({nibble_interface_strap, tx_local_ref_clock_in, recovered_line_clock_in,
      tx_serial_payload_in, tx_frame_reference_in}),
    .syncOut(pinsSynced)
  );

  sync_two_flop #(
    .WIDTH(4)
  ) nibbleBusSync (
    .clock(clock),
    .rst(rst),
    .asyncIn(tx_nibble_payload_in),
    .syncOut(nibbleSync)
  );

  assign strapSync = pinsSynced[4];
  assign refClockSync = pinsSynced[3];
  assign lineClockSync = pinsSynced[2];
  assign serialSync = pinsSynced[1];
  assign frameRefSync = pinsSynced[0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic loopTiming;
    logic frameSlave;
    logic userDataLink;
    logic [7:0] rdData;
    logic refPrev;
    logic linePrev;
    logic frameRefPrev;
    logic startPending;
    logic loopClock;
    logic nibbleClock;
    logic ohWarn;
    logic endOfFrame;
    logic nibbleFrame;
    logic [7:0] frameCount;
    payload_out_t payload;
  } iface_state_t;

  localparam iface_state_t STATE_RESET = '{
    loopTiming: CTRL_LOOP_RESET,
    frameSlave: CTRL_SLAVE_RESET,
    userDataLink: CTRL_USER_LINK_RESET,
    default: '0
  };

  iface_state_t state;
  iface_state_t next_state;

  logic bitEnable;
  logic slaveActive;
  logic refRise;
  logic lineRise;
  logic frameRefRise;
  logic restart;
  logic [COUNT_W-1:0] bitCount;
  logic [COUNT_W-1:0] nextCount;

  // ----------------------------------------------------------------
  // timing reference and bit enable
  // ----------------------------------------------------------------

  // edges are taken from the second synchroniser stage only
  assign refRise = refClockSync && !state.refPrev;
  assign lineRise = lineClockSync && !state.linePrev;
  assign frameRefRise = frameRefSync && !state.frameRefPrev;

  // loop timing ignores the local reference entirely
  assign bitEnable = state.loopTiming ? lineRise : refRise;
  assign slaveActive = state.frameSlave && !state.loopTiming;
  assign restart = slaveActive && state.startPending;

  frame_bit_counter bitCounter (
    .clock(clock),
    .rst(rst),
    .bitEnable(bitEnable),
    .restart(restart),
    .count(bitCount),
    .nextCount(nextCount)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------

  // strap picks transfer width, control picks timing and frame role
  always_comb begin
    if (!strapSync) begin
      if (state.loopTiming) begin
        mode = MODE_SERIAL_LOOP;
      end else if (state.frameSlave) begin
        mode = MODE_SERIAL_SLAVE;
      end else begin
        mode = MODE_SERIAL_MASTER;
      end
    end else begin
      if (state.loopTiming) begin
        mode = MODE_NIBBLE_LOOP;
      end else if (state.frameSlave) begin
        mode = MODE_NIBBLE_SLAVE;
      end else begin
        mode = MODE_NIBBLE_MASTER;
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.refPrev = refClockSync;
    next_state.linePrev = lineClockSync;
    next_state.frameRefPrev = frameRefSync;
    next_state.payload.bitValid = 1'b0;
    next_state.payload.nibbleValid = 1'b0;

    // recovered clock is passed out only in loop timing
    next_state.loopClock = state.loopTiming && lineClockSync;

    // a new frame reference edge wins over consuming the old one
    if (frameRefRise && slaveActive) begin
      next_state.startPending = 1'b1;
    end else if (bitEnable) begin
      next_state.startPending = 1'b0;
    end

    if (bitEnable) begin
      next_state.payload.bitIndex = nextCount;
      // warn for the bit that follows the one now starting
      next_state.ohWarn = isOverhead(followingBit(nextCount));
      next_state.endOfFrame = (nextCount == LAST_BIT);
      // national bit slot, tagged with its link source
      next_state.payload.nationalSlot = (nextCount == NATIONAL_BIT);
      next_state.payload.userDataLink = state.userDataLink;
      if (nextCount == LAST_BIT) begin
        next_state.frameCount = state.frameCount + 8'h01;
      end

      // serial path: strap low, payload bits only
      if (!strapSync && !isOverhead(nextCount)) begin
        next_state.payload.bitValid = 1'b1;
        next_state.payload.payloadBit = serialSync;
      end

      // nibble clock from the bit rate, high over the last two bits
      next_state.nibbleClock = strapSync && nextCount[1];
      next_state.nibbleFrame = strapSync && (nextCount >= LAST_NIBBLE_START);
      if (strapSync && nextCount[1:0] == NIBBLE_SAMPLE_PHASE) begin
        next_state.payload.nibbleValid = 1'b1;
        next_state.payload.nibble = nibbleSync;
      end
    end

    // register port
    next_state.rdData = 8'h00;
    if (regReq.wrStrobe && regReq.addr == CTRL_ADDR) begin
      next_state.loopTiming = regReq.wrData[CTRL_LOOP_POS];
      next_state.frameSlave = regReq.wrData[CTRL_SLAVE_POS];
      next_state.userDataLink = regReq.wrData[CTRL_USER_LINK_POS];
    end
    if (regReq.rdStrobe) begin
      unique case (regReq.addr)
        CTRL_ADDR: begin
          next_state.rdData = {5'h00, state.userDataLink, state.frameSlave, state.loopTiming};
        end
        MODE_ADDR: begin
          next_state.rdData = {4'h0, strapSync, mode};
        end
        FRAMES_ADDR: begin
          next_state.rdData = state.frameCount;
        end
        default: begin
          next_state.rdData = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdData = state.rdData;
  assign loop_payload_clock_out = state.loopClock;
  assign tx_nibble_clock_out = state.nibbleClock;
  assign tx_overhead_warning_out = state.ohWarn;
  assign tx_end_of_frame_out = state.endOfFrame;
  assign tx_nibble_frame_boundary_out = state.nibbleFrame;
  assign payloadOut = state.payload;

endmodule

`default_nettype wire

// *** hdl/e3_tx_pkg.sv ***
package e3_tx_pkg;

  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int FRAME_BITS = 1536;
  localparam int OVERHEAD_BITS = 12;
  localparam int COUNT_W = 11;
  localparam logic [10:0] LAST_BIT = 11'h5FF;
  localparam logic [10:0] FIRST_PAYLOAD_BIT = 11'h00C;
  localparam logic [10:0] NATIONAL_BIT = 11'h00B;
  localparam logic [10:0] LAST_NIBBLE_START = 11'h5FC;
  localparam logic [1:0] NIBBLE_SAMPLE_PHASE = 2'h2;

  // ----------------------------------------------------------------
  // timing figures
  // ----------------------------------------------------------------
  localparam int CLOCK_KHZ = 100000;
  localparam int REF_CLOCK_KHZ = 34368;

  // ----------------------------------------------------------------
  // register map, 8-bit data
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] MODE_ADDR = 4'h1;
  localparam logic [3:0] FRAMES_ADDR = 4'h2;
  localparam int CTRL_LOOP_POS = 0;
  localparam int CTRL_SLAVE_POS = 1;
  localparam int CTRL_USER_LINK_POS = 2;
  localparam logic CTRL_LOOP_RESET = 1'b1;
  localparam logic CTRL_SLAVE_RESET = 1'b0;
  localparam logic CTRL_USER_LINK_RESET = 1'b0;

  // six interface modes, codes as read back from MODE_ADDR
  typedef enum logic [2:0] {
    MODE_SERIAL_LOOP = 3'b001,
    MODE_SERIAL_SLAVE = 3'b010,
    MODE_SERIAL_MASTER = 3'b011,
    MODE_NIBBLE_LOOP = 3'b100,
    MODE_NIBBLE_SLAVE = 3'b101,
    MODE_NIBBLE_MASTER = 3'b110
  } iface_mode_t;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } reg_req_t;

  // payload handed to the framer, one bit or one nibble at a time
  typedef struct packed {
    logic bitValid;
    logic payloadBit;
    logic nibbleValid;
    logic [3:0] nibble;
    logic nationalSlot;
    logic userDataLink;
    logic [10:0] bitIndex;
  } payload_out_t;

endpackage

// *** hdl/frame_bit_counter.sv ***
`timescale 1ns/100ps
`default_nettype none

module frame_bit_counter
  import e3_tx_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic bitEnable,
  input wire logic restart,
  output logic [e3_tx_pkg::COUNT_W-1:0] count,
  output logic [e3_tx_pkg::COUNT_W-1:0] nextCount
);

  typedef struct packed {
    logic [COUNT_W-1:0] count;
  } counter_state_t;

  counter_state_t state;
  counter_state_t next_state;

  // free running over one frame, restart forces bit zero
  always_comb begin
    next_state = state;
    if (restart || state.count == LAST_BIT) begin
      nextCount = '0;
    end else begin
      nextCount = state.count + 11'h001;
    end
    if (bitEnable) begin
      next_state.count = nextCount;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '{count: LAST_BIT};
    end else begin
      state <= next_state;
    end
  end

  assign count = state.count;

endmodule

`default_nettype wire

// *** hdl/sync_two_flop.sv ***
`timescale 1ns/100ps
`default_nettype none

module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // first stage feeds only the second
  always_comb begin
    next_state.first = asyncIn;
    next_state.second = state.first;
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign syncOut = state.second;

endmodule

`default_nettype wire

// *** verif/e3_terminal_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module e3_terminal_model (
  input wire logic ifaceClock,
  input wire logic tx_end_of_frame_out,
  output logic tx_local_ref_clock_in,
  output logic tx_serial_payload_in,
  output logic [3:0] tx_nibble_payload_in,
  output logic [7:0] bitCount
);
  // ----
  // oscillator and payload source
  // ----
  logic [7:0] nxt;
  // free-running local reference, period 29.1 ns
  initial begin
    tx_local_ref_clock_in = 1'b0;
    forever begin
      #14.5 tx_local_ref_clock_in = 1'b1;
      #14.6 tx_local_ref_clock_in = 1'b0;
    end
  end
  // payload moves mid-period in runs, so every sample lands on a settled value
  // end of frame restarts the pattern for the next frame
  assign nxt = tx_end_of_frame_out ? 8'h00 : bitCount + 8'h01;
  initial begin
    bitCount = 8'h00;
    tx_serial_payload_in = 1'b0;
    tx_nibble_payload_in = 4'h0;
  end
  always @(negedge ifaceClock) begin
    bitCount <= nxt;
    tx_serial_payload_in <= nxt[3] ^ nxt[6];
    tx_nibble_payload_in <= nxt[7:4] ^ 4'hA;
  end
endmodule

`default_nettype wire

// *** verif/e3_tx_payload_input_interface_properties.sv ***
`timescale 1ns/100ps
`default_nettype none

module e3_tx_payload_checker (
  input wire logic clock,
  input wire logic rst,
  input wire e3_tx_pkg::reg_req_t regReq,
  input wire logic [7:0] rdData,
  input wire logic nibble_interface_strap,
  input wire logic tx_local_ref_clock_in,
  input wire logic recovered_line_clock_in,
  input wire logic tx_serial_payload_in,
  input wire logic [3:0] tx_nibble_payload_in,
  input wire logic tx_frame_reference_in,
  input wire logic loop_payload_clock_out,
  input wire logic tx_nibble_clock_out,
  input wire logic tx_overhead_warning_out,
  input wire logic tx_end_of_frame_out,
  input wire logic tx_nibble_frame_boundary_out,
  input wire e3_tx_pkg::payload_out_t payloadOut,
  input wire e3_tx_pkg::iface_mode_t mode
);
  import e3_tx_pkg::*;
  // ----
  // mode classes and bit position
  // ----
  logic isNib;
  logic isLoop;
  logic isSlave;
  logic [10:0] idx;
  // decode of the reported mode
  assign isNib = mode inside {MODE_NIBBLE_LOOP, MODE_NIBBLE_SLAVE, MODE_NIBBLE_MASTER};
  assign isLoop = mode inside {MODE_SERIAL_LOOP, MODE_NIBBLE_LOOP};
  assign isSlave = mode inside {MODE_SERIAL_SLAVE, MODE_NIBBLE_SLAVE};
  assign idx = payloadOut.bitIndex;
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // a bit step under a settled mode
  sequence step;
    $stable(mode) [*2] ##0 $changed(idx);
  endsequence
  // a bit step with no frame reference restart possible
  sequence freeStep;
    step ##0 !isSlave;
  endsequence
  // ----
  // properties
  // ----
  eof_last_a:
    assert property (step |-> tx_end_of_frame_out == (idx == LAST_BIT))
    else $error("end of frame off the last bit");
  eof_width_a:
    assert property ($rose(tx_end_of_frame_out) |=> tx_end_of_frame_out ##[1:4] !tx_end_of_frame_out)
    else $error("end of frame width wrong");
  warn_ahead_a:
    assert property (freeStep |->
      tx_overhead_warning_out == (idx == LAST_BIT || idx < NATIONAL_BIT))
    else $error("overhead warning misplaced");
  national_slot_a:
    assert property (step |-> payloadOut.nationalSlot == (idx == NATIONAL_BIT))
    else $error("national slot misplaced");
  payload_gate_a:
    assert property (payloadOut.bitValid && $stable(mode) |->
      !isNib && idx >= FIRST_PAYLOAD_BIT)
    else $error("serial bit taken where it is ignored");
  nibble_gate_a:
    assert property (payloadOut.nibbleValid && $stable(mode) |->
      isNib && idx[1:0] == NIBBLE_SAMPLE_PHASE)
    else $error("nibble taken where it is ignored");
  nibble_clock_a:
    assert property (step |-> tx_nibble_clock_out == (isNib && idx[1]))
    else $error("nibble clock wrong");
  nibble_edge_a:
    assert property (step |->
      tx_nibble_frame_boundary_out == (isNib && idx >= LAST_NIBBLE_START))
    else $error("nibble frame boundary wrong");
  loop_clock_a:
    assert property (!isLoop [*3] |-> !loop_payload_clock_out)
    else $error("loop clock out of loop timing");
  bit_count_a:
    assert property (freeStep |->
      idx == (($past(idx) == LAST_BIT) ? 11'h000 : $past(idx) + 11'h001))
    else $error("bit counter skipped");
endmodule

bind e3_tx_payload_input_interface e3_tx_payload_checker e3_tx_payload_checker_i (
  .clock, .rst, .regReq, .rdData, .nibble_interface_strap, .tx_local_ref_clock_in,
  .recovered_line_clock_in, .tx_serial_payload_in, .tx_nibble_payload_in,
  .tx_frame_reference_in, .loop_payload_clock_out, .tx_nibble_clock_out,
  .tx_overhead_warning_out, .tx_end_of_frame_out, .tx_nibble_frame_boundary_out,
  .payloadOut, .mode
);

`default_nettype wire

// *** verif/test_e3_tx_payload_input_interface.sv ***
`timescale 1ns/100ps
`default_nettype none

module test_e3_tx_payload_input_interface;
  import e3_tx_pkg::*;
  // ----
  // stimulus and wiring
  // ----
  logic clock = 1'b0;
  logic rst = 1'b1;
  e3_tx_pkg::reg_req_t regReq = '0;
  logic [7:0] rdData;
  logic nibble_interface_strap = 1'b0;
  logic recovered_line_clock_in = 1'b0;
  logic tx_frame_reference_in = 1'b0;
  logic tx_local_ref_clock_in, tx_serial_payload_in, ifaceClock, dataOn = 1'b0;
  logic [3:0] tx_nibble_payload_in;
  logic [7:0] bitCount;
  logic [10:0] i0;
  logic [2:0] flags;
  logic [7:0] frameSeen = 8'h00;
  logic eofPrev = 1'b0;
  logic loop_payload_clock_out, tx_nibble_clock_out, tx_overhead_warning_out;
  logic tx_end_of_frame_out, tx_nibble_frame_boundary_out;
  e3_tx_pkg::payload_out_t payloadOut;
  e3_tx_pkg::iface_mode_t mode;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  logic [6:0] strapTbl = 7'b1110000;
  logic [7:0] ctrlTbl [7] = '{8'h01, 8'h03, 8'h02, 8'h00, 8'h01, 8'h02, 8'h00};
  iface_mode_t modeTbl [7] = '{MODE_SERIAL_LOOP, MODE_SERIAL_LOOP, MODE_SERIAL_SLAVE,
    MODE_SERIAL_MASTER, MODE_NIBBLE_LOOP, MODE_NIBBLE_SLAVE, MODE_NIBBLE_MASTER};

  // system clock and a 40 ns recovered line clock
  always #5 clock = ~clock;
  always #20 recovered_line_clock_in = ~recovered_line_clock_in;
  // terminal clocks on the interface clock of the selected timing
  assign ifaceClock = (mode == MODE_SERIAL_LOOP || mode == MODE_NIBBLE_LOOP) ?
    loop_payload_clock_out : tx_local_ref_clock_in;
  assign flags = {payloadOut.bitIndex == 11'h000, tx_nibble_frame_boundary_out,
    tx_end_of_frame_out};

  e3_tx_payload_input_interface e3_tx_payload_input_interface_i (
    .clock, .rst, .regReq, .rdData, .nibble_interface_strap, .tx_local_ref_clock_in,
    .recovered_line_clock_in, .tx_serial_payload_in, .tx_nibble_payload_in,
    .tx_frame_reference_in, .loop_payload_clock_out, .tx_nibble_clock_out,
    .tx_overhead_warning_out, .tx_end_of_frame_out, .tx_nibble_frame_boundary_out,
    .payloadOut, .mode
  );
  e3_terminal_model e3_terminal_model_i (
    .ifaceClock, .tx_end_of_frame_out, .tx_local_ref_clock_in, .tx_serial_payload_in,
    .tx_nibble_payload_in, .bitCount
  );

  // ----
  // tasks
  // ----
  task automatic check(input string w, input logic [10:0] e, input logic [10:0] g);
    cmp_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    regReq <= {a, d, 1'b1, 1'b0};
    @(posedge clock);
    regReq <= '0;
    @(posedge clock);
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [7:0] e);
    regReq <= {a, 8'h00, 1'b0, 1'b1};
    @(posedge clock);
    regReq <= '0;
    #1;
    check("rdData", e, rdData);
    @(posedge clock);
  endtask
  task automatic set_mode(input logic s, input logic [7:0] c);
    nibble_interface_strap <= s;
    reg_write(CTRL_ADDR, c);
    repeat (4) @(posedge clock);
  endtask
  task automatic wait_flag(input int k, input int lim);
    int n;
    n = 0;
    while (flags[k] !== 1'b1 && n < lim) begin
      @(posedge clock);
      n++;
    end
    check("flag", 1, flags[k]);
  endtask
  // bits advanced over 3000 ns, against the selected reference period
  task automatic bit_rate(input int lo, input int hi);
    int adv;
    adv = payloadOut.bitIndex;
    repeat (300) @(posedge clock);
    adv = (payloadOut.bitIndex + 1536 - adv) % 1536;
    check("bit rate", 1, adv >= lo && adv <= hi);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----
  // monitors
  // ----
  // payload taken matches what the terminal held steady, looked at mid-cycle
  always @(negedge clock) begin
    if (dataOn && payloadOut.bitValid === 1'b1 && bitCount[2:0] > 3'h2)
      check("serial", tx_serial_payload_in, payloadOut.payloadBit);
    if (dataOn && payloadOut.nibbleValid === 1'b1 && bitCount[3:0] > 4'h3)
      check("nibble", tx_nibble_payload_in, payloadOut.nibble);
  end
  // end-of-frame pulses seen, held later against the frame counter
  always @(negedge clock) begin
    eofPrev <= tx_end_of_frame_out;
    if (tx_end_of_frame_out === 1'b1 && eofPrev !== 1'b1)
      frameSeen <= frameSeen + 8'h01;
  end
  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_errors++;
      $display("mismatch timeout expected 0 seen %0d", cycles);
      end_sim;
    end
  end

  // ----
  // main sequence
  // ----
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    reg_read(CTRL_ADDR, {5'h00, CTRL_USER_LINK_RESET, CTRL_SLAVE_RESET, CTRL_LOOP_RESET});
    reg_read(MODE_ADDR, {5'h00, MODE_SERIAL_LOOP});
    reg_write(4'hF, 8'hFF);
    reg_read(4'hF, 8'h00);
    for (int k = 0; k < 7; k++) begin
      set_mode(strapTbl[k], ctrlTbl[k]);
      check("mode", modeTbl[k], mode);
      reg_read(MODE_ADDR, {4'h0, strapTbl[k], modeTbl[k]});
    end
    set_mode(1'b0, 8'h05);
    check("user link", 1, payloadOut.userDataLink);
    reg_read(CTRL_ADDR, 8'h05);
    set_mode(1'b0, 8'h01);
    check("user link", 0, payloadOut.userDataLink);
    dataOn = 1'b1;
    bit_rate(73, 77);
    wait_flag(0, 7000);
    set_mode(1'b0, 8'h00);
    bit_rate(101, 105);
    wait_flag(0, 7000);
    repeat (300) @(posedge clock);
    i0 = payloadOut.bitIndex;
    tx_frame_reference_in <= 1'b1;
    repeat (20) @(posedge clock);
    check("master ref", 1, payloadOut.bitIndex > i0);
    tx_frame_reference_in <= 1'b0;
    set_mode(1'b0, 8'h02);
    repeat (300) @(posedge clock);
    tx_frame_reference_in <= 1'b1;
    wait_flag(2, 20);
    tx_frame_reference_in <= 1'b0;
    set_mode(1'b1, 8'h00);
    wait_flag(1, 7000);
    wait_flag(0, 20);
    reg_read(FRAMES_ADDR, frameSeen);
    set_mode(1'b1, 8'h01);
    bit_rate(73, 77);
    end_sim;
  end
endmodule

`default_nettype wire
